// File: hw/tsr_pkg.sv
package tsr_pkg;

  // ----------------------------------------------------------------
  // register offsets of the second timestamp slot
  // ----------------------------------------------------------------
  localparam logic [7:0] TSR_OFS_SUBSEC = 8'h30;
  localparam logic [7:0] TSR_OFS_SEC = 8'h31;
  localparam logic [7:0] TSR_OFS_MIN = 8'h32;
  localparam logic [7:0] TSR_OFS_HOUR = 8'h33;
  localparam logic [7:0] TSR_OFS_DATE = 8'h34;
  localparam logic [7:0] TSR_OFS_MONTH = 8'h35;
  localparam logic [7:0] TSR_OFS_YEAR = 8'h36;
  localparam logic [7:0] TSR_OFS_FLAGS = 8'h37;

  // ----------------------------------------------------------------
  // implemented bits of each register, reserved bits read zero
  // ----------------------------------------------------------------
  localparam logic [7:0] TSR_MASK_SUBSEC = 8'h7F;
  localparam logic [7:0] TSR_MASK_SEC = 8'h7F;
  localparam logic [7:0] TSR_MASK_MIN = 8'h7F;
  localparam logic [7:0] TSR_MASK_HOUR = 8'h7F;
  localparam logic [7:0] TSR_MASK_DATE = 8'h3F;
  localparam logic [7:0] TSR_MASK_MONTH = 8'h9F;
  localparam logic [7:0] TSR_MASK_YEAR = 8'hFF;
  localparam logic [7:0] TSR_MASK_FLAGS = 8'h0F;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TSR_RST_SUBSEC = 8'h00;
  localparam logic [7:0] TSR_RST_SEC = 8'h00;
  localparam logic [7:0] TSR_RST_MIN = 8'h00;
  localparam logic [7:0] TSR_RST_HOUR = 8'h00;
  localparam logic [7:0] TSR_RST_DATE = 8'h00;
  localparam logic [7:0] TSR_RST_MONTH = 8'h00;
  localparam logic [7:0] TSR_RST_YEAR = 8'h00;
  localparam logic [7:0] TSR_RST_FLAGS = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TSR_HOUR_FMT_BIT = 6;
  localparam int TSR_HOUR_HALF_BIT = 5;
  localparam int TSR_HOUR_TENS_BIT = 4;
  localparam int TSR_CENTURY_BIT = 7;
  localparam int TSR_FLAG_LOW_V_BIT = 3;
  localparam int TSR_FLAG_TO_BKP_BIT = 2;
  localparam int TSR_FLAG_TO_MAIN_BIT = 1;
  localparam int TSR_FLAG_PIN_BIT = 0;

  // live calendar value offered for capture, in register layout
  typedef struct packed {
    logic [6:0] sub_second;
    logic [2:0] seconds_tens_digit;
    logic [3:0] seconds_units;
    logic [2:0] minutes_tens;
    logic [3:0] minutes_units;
    logic hour_12h_format;
    logic half_day_or_twenties_bit;
    logic hour_tens_digit;
    logic [3:0] hour_units;
    logic [1:0] date_tens;
    logic [3:0] date_units;
    logic century;
    logic month_tens;
    logic [3:0] month_units;
    logic [3:0] year_tens;
    logic [3:0] year_units;
  } tsr_cal_t;

  // cause of a capture
  typedef struct packed {
    logic low_voltage_detect;
    logic to_backup;
    logic to_main;
    logic event_pin;
  } tsr_cause_t;

  // register access from the serial bus engine
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } tsr_req_t;

  // whole state of the slot
  typedef struct packed {
    logic [7:0] subsec;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] flags;
    logic [7:0] rd_data;
    logic [4:0] hour_24;
  } tsr_state_t;

endpackage

// File: hw/tsr_slot.sv
`timescale 1ns/10ps

// Behaviour
// - hour bit 6 clear selects 24-hour count 0..23, set selects 12-hour 1..12
// - in 12-hour mode hour bit 5 is the half-day flag, 0 morning, 1 afternoon
// - in 24-hour mode hour bit 5 is the BCD twenties-of-hours digit
// - hour bit 4 is the tens digit, bits 3..0 the units digit
// - seconds and minutes keep tens in bits 6..4 and units in bits 3..0
// - cause bit 3 set when low-voltage detection caused the capture
// - cause bit 2 set when a main-to-backup supply switch caused it
// - cause bit 1 set when a backup-to-main supply switch caused it
// - cause bit 0 set when an event pin transition caused it
module tsr_slot (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // capture from the trigger logic
  input wire logic capture_stb,
  input wire tsr_pkg::tsr_cal_t live_cal,
  input wire tsr_pkg::tsr_cause_t cause,
  // register access
  input wire tsr_pkg::tsr_req_t req,
  output logic [7:0] rd_data,
  output logic hit,
  // decoded view of the stored record
  output tsr_pkg::tsr_cause_t stored_cause,
  output logic [4:0] stored_hour_24,
  output logic stored_is_pm
);
  import tsr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tsr_state_t state;
  tsr_state_t next_state;
  logic capture_take;
  logic [7:0] cap_subsec;
  logic [7:0] cap_sec;
  logic [7:0] cap_min;
  logic [7:0] cap_hour;
  logic [7:0] cap_date;
  logic [7:0] cap_month;
  logic [7:0] cap_year;
  logic [7:0] cap_flags;

  // ----------------------------------------------------------------
  // bcd hour to 0..23
  // ----------------------------------------------------------------
  function automatic logic [4:0] hour_to_24(input logic [7:0] h);
    logic [4:0] units;
    logic [4:0] val;
    units = {1'b0, h[3:0]};
    val = 5'h00;
    if (h[TSR_HOUR_FMT_BIT])
    begin
      // 12-hour: 1..12 with half-day flag; 12 AM is midnight
      val = (h[TSR_HOUR_TENS_BIT] ? 5'h0A : 5'h00) + units;
      if (h[TSR_HOUR_HALF_BIT] && val != 5'h0C)
      begin
        val = val + 5'h0C;
      end
      else if (!h[TSR_HOUR_HALF_BIT] && val == 5'h0C)
      begin
        val = 5'h00;
      end
    end
    else
    begin
      // 24-hour: twenties digit, tens digit, units
      val = (h[TSR_HOUR_HALF_BIT] ? 5'h14 : 5'h00)
        + (h[TSR_HOUR_TENS_BIT] ? 5'h0A : 5'h00) + units;
    end
    return val;
  endfunction

  // ----------------------------------------------------------------
  // capture image
  // ----------------------------------------------------------------
  // a capture only counts when some cause is present, so the cause
  // register never shows an all-zero record written by hardware
  assign capture_take = capture_stb && (cause != 4'h0);

  // binary fractions taken at the same edge as the calendar
  assign cap_subsec = {1'b0, live_cal.sub_second} & TSR_MASK_SUBSEC;

  // seconds and minutes share one layout
  assign cap_sec = {1'b0, live_cal.seconds_tens_digit, live_cal.seconds_units};
  assign cap_min = {1'b0, live_cal.minutes_tens, live_cal.minutes_units};

  // hour keeps its format bit so the meaning of bit 5 travels with it
  assign cap_hour = {1'b0, live_cal.hour_12h_format,
    live_cal.half_day_or_twenties_bit,
    live_cal.hour_tens_digit, live_cal.hour_units};

  // date, month with century, year in bcd
  assign cap_date = {2'b00, live_cal.date_tens, live_cal.date_units};
  assign cap_month = {live_cal.century, 2'b00, live_cal.month_tens,
    live_cal.month_units};
  assign cap_year = {live_cal.year_tens, live_cal.year_units};

  // each cause lands in its own flag bit
  always_comb
  begin
    cap_flags = 8'h00;
    cap_flags[TSR_FLAG_LOW_V_BIT] = cause.low_voltage_detect;
    cap_flags[TSR_FLAG_TO_BKP_BIT] = cause.to_backup;
    cap_flags[TSR_FLAG_TO_MAIN_BIT] = cause.to_main;
    cap_flags[TSR_FLAG_PIN_BIT] = cause.event_pin;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // a capture in the same cycle as a write wins: losing an event is
  // worse than losing a software write to a record it should not edit
  always_comb
  begin
    next_state = state;
    if (capture_take)
    begin
      next_state.subsec = cap_subsec;
      next_state.sec = cap_sec;
      next_state.min = cap_min;
      next_state.hour = cap_hour;
      next_state.date = cap_date;
      next_state.month = cap_month;
      next_state.year = cap_year;
      next_state.flags = cap_flags;
    end
    else if (req.wr)
    begin
      case (req.addr)
        TSR_OFS_SUBSEC: next_state.subsec = req.wdata & TSR_MASK_SUBSEC;
        TSR_OFS_SEC: next_state.sec = req.wdata & TSR_MASK_SEC;
        TSR_OFS_MIN: next_state.min = req.wdata & TSR_MASK_MIN;
        TSR_OFS_HOUR: next_state.hour = req.wdata & TSR_MASK_HOUR;
        TSR_OFS_DATE: next_state.date = req.wdata & TSR_MASK_DATE;
        TSR_OFS_MONTH: next_state.month = req.wdata & TSR_MASK_MONTH;
        TSR_OFS_YEAR: next_state.year = req.wdata & TSR_MASK_YEAR;
        TSR_OFS_FLAGS: next_state.flags = req.wdata & TSR_MASK_FLAGS;
        default: next_state.flags = state.flags;
      endcase
    end

    // read data is sampled from the registers before this edge
    if (req.rd)
    begin
      case (req.addr)
        TSR_OFS_SUBSEC: next_state.rd_data = state.subsec;
        TSR_OFS_SEC: next_state.rd_data = state.sec;
        TSR_OFS_MIN: next_state.rd_data = state.min;
        TSR_OFS_HOUR: next_state.rd_data = state.hour;
        TSR_OFS_DATE: next_state.rd_data = state.date;
        TSR_OFS_MONTH: next_state.rd_data = state.month;
        TSR_OFS_YEAR: next_state.rd_data = state.year;
        TSR_OFS_FLAGS: next_state.rd_data = state.flags;
        default: next_state.rd_data = 8'h00;
      endcase
    end

    // decoded hour is registered at the same edge as the stored hour
    next_state.hour_24 = hour_to_24(next_state.hour);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state.subsec <= TSR_RST_SUBSEC;
      state.sec <= TSR_RST_SEC;
      state.min <= TSR_RST_MIN;
      state.hour <= TSR_RST_HOUR;
      state.date <= TSR_RST_DATE;
      state.month <= TSR_RST_MONTH;
      state.year <= TSR_RST_YEAR;
      state.flags <= TSR_RST_FLAGS;
      state.rd_data <= 8'h00;
      state.hour_24 <= 5'h00;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // hit is combinational so the bus engine can decide its acknowledge
  assign hit = (req.addr >= TSR_OFS_SUBSEC) && (req.addr <= TSR_OFS_FLAGS);
  assign rd_data = state.rd_data;
  assign stored_cause.low_voltage_detect = state.flags[TSR_FLAG_LOW_V_BIT];
  assign stored_cause.to_backup = state.flags[TSR_FLAG_TO_BKP_BIT];
  assign stored_cause.to_main = state.flags[TSR_FLAG_TO_MAIN_BIT];
  assign stored_cause.event_pin = state.flags[TSR_FLAG_PIN_BIT];
  assign stored_hour_24 = state.hour_24;
  // afternoon in either mode, taken from the decoded hour
  assign stored_is_pm = (state.hour_24 >= 5'h0C);

endmodule // tsr_slot

// File: sim/tsr_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// bus engine side: single byte register requests
// ----------------------------------------------------------------
module tsr_host_model (
  // clock
  input wire logic sys_clk,
  // register access
  input wire logic [7:0] rd_data,
  output tsr_pkg::tsr_req_t req
);
  import tsr_pkg::*;
  // idle bus from time zero
  initial req = '0;
  // one request held for one edge; read data taken once that edge has landed
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge sys_clk);
    req <= '{addr: a, wr: w, rd: !w, wdata: d};
    @(negedge sys_clk);
    req <= '0;
    q = rd_data;
  endtask
endmodule // tsr_host_model

// File: sim/tsr_slot_monitor.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// port checker for the timestamp slot
// ----------------------------------------------------------------
module tsr_slot_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // capture and register access
  input wire logic capture_stb,
  input wire tsr_pkg::tsr_cal_t live_cal,
  input wire tsr_pkg::tsr_cause_t cause,
  input wire tsr_pkg::tsr_req_t req,
  input wire logic [7:0] rd_data,
  input wire logic hit,
  // decoded record
  input wire tsr_pkg::tsr_cause_t stored_cause,
  input wire logic [4:0] stored_hour_24,
  input wire logic stored_is_pm
);
  import tsr_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic tk;
  logic [4:0] cap_h;
  // a capture only counts with a cause; hour weighed as twenties, tens, units
  assign tk = capture_stb && (cause != 4'h0);
  assign cap_h = (live_cal.half_day_or_twenties_bit ? 5'h14 : 5'h00)
    + (live_cal.hour_tens_digit ? 5'h0A : 5'h00) + {1'b0, live_cal.hour_units};
  a_low_volt_flag: assert property (tk |=> stored_cause.low_voltage_detect ==
    $past(cause.low_voltage_detect)) else $error("low voltage flag wrong");
  a_to_backup_flag: assert property (tk |=> stored_cause.to_backup ==
    $past(cause.to_backup)) else $error("to backup flag wrong");
  a_to_main_flag: assert property (tk |=> stored_cause.to_main ==
    $past(cause.to_main)) else $error("to main flag wrong");
  a_event_pin_flag: assert property (tk |=> stored_cause.event_pin ==
    $past(cause.event_pin)) else $error("event pin flag wrong");
  a_hour_24_decode: assert property (tk && !live_cal.hour_12h_format |=>
    stored_hour_24 == $past(cap_h)) else $error("24 hour decode wrong");
  a_half_day_pm: assert property (tk && live_cal.hour_12h_format |=>
    stored_is_pm == $past(live_cal.half_day_or_twenties_bit)) else $error("half day wrong");
  a_subsec_capture: assert property (tk ##1 (req.rd && req.addr == TSR_OFS_SUBSEC) |=>
    rd_data == {1'b0, $past(live_cal.sub_second, 2)}) else $error("sub-second wrong");
  a_seconds_layout: assert property (tk ##1 (req.rd && req.addr == TSR_OFS_SEC) |=>
    rd_data == {1'b0, $past(live_cal.seconds_tens_digit, 2), $past(live_cal.seconds_units, 2)})
    else $error("seconds layout wrong");
  a_year_layout: assert property (tk ##1 (req.rd && req.addr == TSR_OFS_YEAR) |=>
    rd_data == {$past(live_cal.year_tens, 2), $past(live_cal.year_units, 2)})
    else $error("year layout wrong");
  // the slot answers only inside its own eight-byte window
  a_hit_range: assert property (hit == (req.addr >= TSR_OFS_SUBSEC && req.addr <= TSR_OFS_FLAGS))
    else $error("hit decode wrong");
  a_unmapped_read: assert property (req.rd && !hit |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  c_capture: cover property (tk);
  c_capture_write_clash: cover property (tk && req.wr);
  c_twelve_hour: cover property (tk && live_cal.hour_12h_format);
  c_read_hit: cover property (req.rd && hit);
endmodule // tsr_slot_monitor

bind tsr_slot tsr_slot_monitor mon_u (.sys_clk(sys_clk), .rst(rst), .capture_stb(capture_stb),
  .live_cal(live_cal), .cause(cause), .req(req), .rd_data(rd_data), .hit(hit),
  .stored_cause(stored_cause), .stored_hour_24(stored_hour_24), .stored_is_pm(stored_is_pm));

// File: sim/tsr_slot_tb_top.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// testbench for the timestamp slot
// ----------------------------------------------------------------
module tsr_slot_tb_top;
  import tsr_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic capture_stb = 1'b0;
  tsr_cal_t live_cal = '0;
  tsr_cause_t cause = '0;
  tsr_req_t req;
  logic [7:0] rd_data;
  logic [7:0] q;
  tsr_cause_t stored_cause;
  logic [4:0] stored_hour_24;
  logic stored_is_pm;
  logic hit;
  int bad_count = 0;
  int checks = 0;
  logic [7:0] msk [8] = '{TSR_MASK_SUBSEC, TSR_MASK_SEC, TSR_MASK_MIN, TSR_MASK_HOUR,
    TSR_MASK_DATE, TSR_MASK_MONTH, TSR_MASK_YEAR, TSR_MASK_FLAGS};
  // 100 ns clock
  always #50 sys_clk = ~sys_clk;
  tsr_slot dut_u (.sys_clk(sys_clk), .rst(rst), .capture_stb(capture_stb),
    .live_cal(live_cal), .cause(cause), .req(req), .rd_data(rd_data), .hit(hit),
    .stored_cause(stored_cause), .stored_hour_24(stored_hour_24), .stored_is_pm(stored_is_pm));
  tsr_host_model host_u (.sys_clk(sys_clk), .rd_data(rd_data), .req(req));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd_chk(input int i, input logic [7:0] e, input string n);
    host_u.xfer(1'b0, TSR_OFS_SUBSEC + 8'(i), 8'h00, q);
    chk(n, e, q);
  endtask
  // calendar from register images, so stimulus reads like the record
  function automatic tsr_cal_t mk(input logic [7:0] s, c, m, h, d, mo, y);
    return {s[6:0], c[6:0], m[6:0], h[6:0], d[5:0], mo[7], mo[4:0], y};
  endfunction
  // expected register image worked out from the field layout
  function automatic logic [7:0] img(input int i, input tsr_cal_t c, input tsr_cause_t k);
    logic [7:0] e [8];
    e = '{{1'b0, c.sub_second}, {1'b0, c.seconds_tens_digit, c.seconds_units},
      {1'b0, c.minutes_tens, c.minutes_units}, {1'b0, c.hour_12h_format,
      c.half_day_or_twenties_bit, c.hour_tens_digit, c.hour_units},
      {2'b00, c.date_tens, c.date_units}, {c.century, 2'b00, c.month_tens, c.month_units},
      {c.year_tens, c.year_units}, {4'h0, k}};
    return e[i];
  endfunction
  // capture, read one register in the very next cycle, then the whole record
  task automatic cap(input tsr_cal_t c, input tsr_cause_t k, input int f);
    @(negedge sys_clk);
    live_cal <= c;
    cause <= k;
    capture_stb <= 1'b1;
    fork
      host_u.xfer(1'b0, TSR_OFS_SUBSEC + 8'(f), 8'h00, q);
      begin
        @(negedge sys_clk);
        capture_stb <= 1'b0;
        cause <= '0;
      end
    join
    chk("first read", img(f, c, k), q);
    for (int i = 0; i < 8; i++) rd_chk(i, img(i, c, k), "record");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd_chk(i, 8'h00, "reset value");
    $display("test reset values done");
    for (int i = 0; i < 8; i++)
    begin
      host_u.xfer(1'b1, TSR_OFS_SUBSEC + 8'(i), 8'hFF, q);
      rd_chk(i, msk[i], "masked write");
    end
    host_u.xfer(1'b1, 8'h2F, 8'hA5, q);
    rd_chk(-1, 8'h00, "unmapped read");
    $display("test write and read done");
    host_u.xfer(1'b1, TSR_OFS_HOUR, 8'h72, q);
    chk("12 pm", 8'h0C, {3'b000, stored_hour_24});
    host_u.xfer(1'b1, TSR_OFS_HOUR, 8'h52, q);
    chk("12 am", 8'h00, {3'b000, stored_hour_24});
    chk("am flag", 8'h00, {7'h00, stored_is_pm});
    $display("test hour decode done");
    cap(mk(8'h7F, 8'h59, 8'h47, 8'h23, 8'h31, 8'h92, 8'h99), 4'b1000, 0);
    chk("hour 23", 8'h17, {3'b000, stored_hour_24});
    cap(mk(8'h01, 8'h30, 8'h05, 8'h71, 8'h09, 8'h80, 8'h00), 4'b0100, 1);
    chk("11 pm", 8'h17, {3'b000, stored_hour_24});
    cap(mk(8'h40, 8'h00, 8'h00, 8'h52, 8'h01, 8'h01, 8'h21), 4'b0010, 6);
    cap(mk(8'h55, 8'h12, 8'h34, 8'h19, 8'h15, 8'h10, 8'h45), 4'b0001, 2);
    chk("stored cause", 8'h01, {4'h0, stored_cause});
    // a capture with no cause must leave the record alone
    @(negedge sys_clk);
    live_cal <= '0;
    capture_stb <= 1'b1;
    @(negedge sys_clk);
    capture_stb <= 1'b0;
    rd_chk(7, 8'h01, "no cause capture");
    $display("test captures done");
    // a capture and a flag write at one edge: the capture must win
    fork
      host_u.xfer(1'b1, TSR_OFS_FLAGS, 8'h05, q);
      begin
        @(negedge sys_clk);
        cause <= 4'b0100;
        capture_stb <= 1'b1;
        @(negedge sys_clk);
        capture_stb <= 1'b0;
        cause <= '0;
      end
    join
    rd_chk(7, 8'h04, "capture beats write");
    $display("test capture against write done");
    // a reset in mid-run clears the whole record again
    @(negedge sys_clk);
    rst <= 1'b1;
    @(negedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd_chk(i, 8'h00, "mid-run reset");
    chk("cause after reset", 8'h00, {4'h0, stored_cause});
    $display("test mid-run reset done");
    conclude;
  end
  // watchdog: the tests need well under 3000 cycles
  initial
  begin
    #300000;
    bad_count++;
    conclude;
  end
endmodule // tsr_slot_tb_top
